// *** verilog/upfic_defs.svh ***
// Purpose: offsets, field positions, reset values for the usb power/frame/interrupt block
// Assumes: 8-bit indexed usb register port
// Notes: definitions only
`ifndef UPFIC_DEFS_SVH
`define UPFIC_DEFS_SVH

// =====================================================
// register indexes
`define UPFIC_ADDR_POWER 8'h01
`define UPFIC_ADDR_COMMON_EVENT_FLAGS 8'h06
`define UPFIC_ADDR_CMIE 8'h0b
`define UPFIC_ADDR_FRAME_LOW 8'h0c
`define UPFIC_ADDR_FRAME_HIGH 8'h0d

// =====================================================
// power control fields
`define UPFIC_PWR_ISO_UPDATE 7
`define UPFIC_PWR_INHIBIT 4
`define UPFIC_PWR_FORCE_RESET 3
`define UPFIC_PWR_RESUME 2
`define UPFIC_PWR_SUSPEND 1
`define UPFIC_PWR_SUSP_DET_EN 0

// =====================================================
// common event flag fields
`define UPFIC_CM_SOF 3
`define UPFIC_CM_RESET 2
`define UPFIC_CM_RESUME 1
`define UPFIC_CM_SUSPEND 0
`define UPFIC_CM_WIDTH 4
`define UPFIC_CMIE_RESET_VAL 4'hf

// =====================================================
// frame number
`define UPFIC_FRAME_WIDTH 11
`define UPFIC_FRAME_HIGH_WIDTH 3
`define UPFIC_BYTE_ZERO 8'h00

// =====================================================
// input synchroniser depth
`define UPFIC_SYNC_STAGES 3

`endif

// *** verilog/upfic_pkg.sv ***
// Purpose: shared types for the usb power/frame/interrupt block
// Assumes: nothing
// Notes: constants live in upfic_defs.svh
package upfic_pkg;

  // =====================================================
  // isochronous in endpoint packet state
  typedef enum logic [1:0] {
    UPFIC_EP_EMPTY = 2'b00,
    UPFIC_EP_WAIT_SOF = 2'b01,
    UPFIC_EP_ARMED = 2'b10
  } upfic_ep_state_t;

  typedef logic [7:0] upfic_byte_t;

endpackage : upfic_pkg

// *** verilog/upfic_in_gate.sv ***
// Purpose: per-endpoint in packet release gate
// Assumes: token, load and sof strobes are one-cycle pulses on sys_clk_i
// Notes: one instance per in endpoint
module upfic_in_gate (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // control
  input wire logic iso_ep_i,
  input wire logic iso_update_i,
  // events
  input wire logic load_i,
  input wire logic sof_i,
  input wire logic token_i,
  // answers
  output logic send_o,
  output logic zero_len_o,
  output logic nak_o
);
  import upfic_pkg::*;

  upfic_ep_state_t state_q, state_d;
  logic send_q, send_d;
  logic zlp_q, zlp_d;
  logic nak_q, nak_d;

  // =====================================================
  // next state
  always_comb begin
    state_d = state_q;
    send_d = 1'b0;
    zlp_d = 1'b0;
    nak_d = 1'b0;
    case (state_q)
      UPFIC_EP_EMPTY: begin
        if (token_i) begin
          zlp_d = iso_ep_i;
          nak_d = ~iso_ep_i;
        end
        if (load_i) begin
          if (iso_ep_i && iso_update_i) begin
            state_d = UPFIC_EP_WAIT_SOF;
          end else begin
            state_d = UPFIC_EP_ARMED;
          end
        end
      end
      UPFIC_EP_WAIT_SOF: begin
        if (token_i) begin
          zlp_d = 1'b1;
        end
        if (sof_i) begin
          state_d = UPFIC_EP_ARMED;
        end
      end
      UPFIC_EP_ARMED: begin
        if (token_i) begin
          send_d = 1'b1;
          state_d = UPFIC_EP_EMPTY;
        end
      end
      default: begin
        state_d = UPFIC_EP_EMPTY;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= UPFIC_EP_EMPTY;
      send_q <= 1'b0;
      zlp_q <= 1'b0;
      nak_q <= 1'b0;
    end else begin
      state_q <= state_d;
      send_q <= send_d;
      zlp_q <= zlp_d;
      nak_q <= nak_d;
    end
  end

  assign send_o = send_q;
  assign zero_len_o = zlp_q;
  assign nak_o = nak_q;

endmodule : upfic_in_gate

// *** verilog/upfic_top.sv ***
// Purpose: usb power control, frame number and common interrupt logic
// Assumes: cpu reaches registers by index; link events are sys_clk_i pulses; bus line states are async
// Notes: usb registers also reset by the force-reset bit
`include "upfic_defs.svh"

module upfic_top #(
  parameter int NUM_IN_EP = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // indexed register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire upfic_pkg::upfic_byte_t reg_wdata_i,
  output upfic_pkg::upfic_byte_t reg_rdata_o,
  // link events from the protocol engine
  input wire logic sof_valid_i,
  input wire logic [`UPFIC_FRAME_WIDTH-1:0] sof_frame_i,
  input wire logic in_token_i,
  input wire logic [NUM_IN_EP-1:0] in_token_ep_i,
  input wire logic [NUM_IN_EP-1:0] in_packet_loaded_i,
  input wire logic [NUM_IN_EP-1:0] ep_is_iso_i,
  // bus line states from transceiver
  input wire logic bus_suspend_i,
  input wire logic bus_resume_i,
  input wire logic bus_reset_i,
  // system interrupt enable
  input wire logic system_ext_irq_enable_i,
  // in endpoint answers
  output logic [NUM_IN_EP-1:0] in_send_o,
  output logic [NUM_IN_EP-1:0] in_zero_len_o,
  output logic [NUM_IN_EP-1:0] in_nak_o,
  // status
  output logic usb_inhibit_o,
  output logic suspend_status_o,
  output logic resume_drive_o,
  output logic usb_irq_o,
  output logic cpu_irq_o
);
  import upfic_pkg::*;

  // =====================================================
  // force reset: one-cycle pulse from a flop, then async into usb domain
  logic force_rst_q, force_rst_d;
  logic usb_rstn;

  always_comb begin
    force_rst_d = reg_wr_i && (reg_addr_i == `UPFIC_ADDR_POWER) && reg_wdata_i[`UPFIC_PWR_FORCE_RESET];
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      force_rst_q <= 1'b0;
    end else begin
      force_rst_q <= force_rst_d;
    end
  end

  assign usb_rstn = resetn_i & ~force_rst_q;

  // =====================================================
  // bus line synchronisers
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] line_async;
  logic [NSYNC-1:0] line_q;
  logic [NSYNC-1:0] line_prev_q;

  assign line_async = {bus_reset_i, bus_resume_i, bus_suspend_i};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [`UPFIC_SYNC_STAGES-1:0] sh_q, sh_d;
      logic lvl_q, lvl_d, prev_q;
      always_comb begin
        sh_d = {sh_q[`UPFIC_SYNC_STAGES-2:0], line_async[gi]};
        lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
      end
      always_ff @(posedge sys_clk_i or negedge usb_rstn) begin
        if (!usb_rstn) begin
          sh_q <= '0;
          lvl_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          sh_q <= sh_d;
          lvl_q <= lvl_d;
          prev_q <= lvl_q;
        end
      end
      assign line_q[gi] = lvl_q;
      assign line_prev_q[gi] = prev_q;
    end
  endgenerate

  // =====================================================
  // power control register
  logic iso_update_q, iso_update_d;
  logic inhibit_q, inhibit_d;
  logic resume_q, resume_d;
  logic suspend_q, suspend_d;
  logic susp_det_en_q, susp_det_en_d;
  logic wakeup_q, wakeup_d;
  logic resume_seen_q, resume_seen_d;
  logic pwr_wr;
  logic cm_rd;
  logic ev_suspend, ev_resume, ev_reset;

  assign pwr_wr = reg_wr_i && (reg_addr_i == `UPFIC_ADDR_POWER);
  assign cm_rd = reg_rd_i && (reg_addr_i == `UPFIC_ADDR_COMMON_EVENT_FLAGS);
  assign ev_suspend = line_q[0] & ~line_prev_q[0] & ~inhibit_q;
  assign ev_resume = line_q[1] & ~line_prev_q[1] & ~inhibit_q;
  assign ev_reset = line_q[2] & ~line_prev_q[2] & ~inhibit_q;

  always_comb begin
    iso_update_d = iso_update_q;
    inhibit_d = inhibit_q;
    resume_d = resume_q;
    suspend_d = suspend_q;
    susp_det_en_d = susp_det_en_q;
    wakeup_d = wakeup_q;
    resume_seen_d = resume_seen_q;
    if (pwr_wr) begin
      iso_update_d = reg_wdata_i[`UPFIC_PWR_ISO_UPDATE];
      susp_det_en_d = reg_wdata_i[`UPFIC_PWR_SUSP_DET_EN];
      if (!reg_wdata_i[`UPFIC_PWR_INHIBIT]) begin
        inhibit_d = 1'b0;
      end
      if (reg_wdata_i[`UPFIC_PWR_RESUME]) begin
        if (suspend_q) begin
          resume_d = 1'b1;
          wakeup_d = 1'b1;
        end
      end else begin
        resume_d = 1'b0;
        if (wakeup_q) begin
          suspend_d = 1'b0;
          wakeup_d = 1'b0;
        end
      end
    end
    if (cm_rd && resume_seen_q) begin
      suspend_d = 1'b0;
      resume_seen_d = 1'b0;
    end
    if (ev_resume && suspend_q) begin
      resume_seen_d = 1'b1;
    end
    if (ev_reset) begin
      suspend_d = 1'b0;
      resume_seen_d = 1'b0;
      wakeup_d = 1'b0;
    end
    if (ev_suspend && susp_det_en_q) begin
      suspend_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge usb_rstn) begin
    if (!usb_rstn) begin
      iso_update_q <= 1'b0;
      inhibit_q <= 1'b1;
      resume_q <= 1'b0;
      suspend_q <= 1'b0;
      susp_det_en_q <= 1'b0;
      wakeup_q <= 1'b0;
      resume_seen_q <= 1'b0;
    end else begin
      iso_update_q <= iso_update_d;
      inhibit_q <= inhibit_d;
      resume_q <= resume_d;
      suspend_q <= suspend_d;
      susp_det_en_q <= susp_det_en_d;
      wakeup_q <= wakeup_d;
      resume_seen_q <= resume_seen_d;
    end
  end

  // =====================================================
  // frame number
  logic [`UPFIC_FRAME_WIDTH-1:0] frame_q, frame_d;
  logic sof_ok;

  assign sof_ok = sof_valid_i & ~inhibit_q;

  always_comb begin
    frame_d = frame_q;
    if (sof_ok) begin
      frame_d = sof_frame_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge usb_rstn) begin
    if (!usb_rstn) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

  // =====================================================
  // common event flags and enables
  logic [`UPFIC_CM_WIDTH-1:0] cm_flags_q, cm_flags_d;
  logic [`UPFIC_CM_WIDTH-1:0] cm_en_q, cm_en_d;
  logic [`UPFIC_CM_WIDTH-1:0] cm_set;
  logic usb_irq_q, usb_irq_d;
  logic cpu_irq_q, cpu_irq_d;

  assign cm_set = {sof_ok, ev_reset, ev_resume & suspend_q, ev_suspend & susp_det_en_q};

  always_comb begin
    cm_en_d = cm_en_q;
    if (reg_wr_i && (reg_addr_i == `UPFIC_ADDR_CMIE)) begin
      cm_en_d = reg_wdata_i[`UPFIC_CM_WIDTH-1:0];
    end
    cm_flags_d = cm_flags_q;
    if (cm_rd) begin
      cm_flags_d = '0;
    end
    cm_flags_d = cm_flags_d | (cm_set & cm_en_q);
    usb_irq_d = |cm_flags_d;
    cpu_irq_d = usb_irq_d & system_ext_irq_enable_i;
  end

  always_ff @(posedge sys_clk_i or negedge usb_rstn) begin
    if (!usb_rstn) begin
      cm_flags_q <= '0;
      cm_en_q <= `UPFIC_CMIE_RESET_VAL;
      usb_irq_q <= 1'b0;
      cpu_irq_q <= 1'b0;
    end else begin
      cm_flags_q <= cm_flags_d;
      cm_en_q <= cm_en_d;
      usb_irq_q <= usb_irq_d;
      cpu_irq_q <= cpu_irq_d;
    end
  end

  // =====================================================
  // register read
  upfic_byte_t rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `UPFIC_ADDR_POWER: begin
          rdata_d = `UPFIC_BYTE_ZERO;
          rdata_d[`UPFIC_PWR_ISO_UPDATE] = iso_update_q;
          rdata_d[`UPFIC_PWR_INHIBIT] = inhibit_q;
          rdata_d[`UPFIC_PWR_FORCE_RESET] = line_q[2];
          rdata_d[`UPFIC_PWR_RESUME] = resume_q;
          rdata_d[`UPFIC_PWR_SUSPEND] = suspend_q;
          rdata_d[`UPFIC_PWR_SUSP_DET_EN] = susp_det_en_q;
        end
        `UPFIC_ADDR_COMMON_EVENT_FLAGS: begin
          rdata_d = {{(8-`UPFIC_CM_WIDTH){1'b0}}, cm_flags_q};
        end
        `UPFIC_ADDR_CMIE: begin
          rdata_d = {{(8-`UPFIC_CM_WIDTH){1'b0}}, cm_en_q};
        end
        `UPFIC_ADDR_FRAME_LOW: begin
          rdata_d = frame_q[7:0];
        end
        `UPFIC_ADDR_FRAME_HIGH: begin
          rdata_d = {5'h00, frame_q[`UPFIC_FRAME_WIDTH-1:8]};
        end
        default: begin
          rdata_d = `UPFIC_BYTE_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge usb_rstn) begin
    if (!usb_rstn) begin
      rdata_q <= `UPFIC_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // =====================================================
  // in endpoint gates, one iso update bit for all
  generate
    for (gi = 0; gi < NUM_IN_EP; gi++) begin : g_ep
      upfic_in_gate u_gate (
        .sys_clk_i(sys_clk_i),
        .resetn_i(usb_rstn),
        .iso_ep_i(ep_is_iso_i[gi]),
        .iso_update_i(iso_update_q),
        .load_i(in_packet_loaded_i[gi]),
        .sof_i(sof_ok),
        .token_i(in_token_i & in_token_ep_i[gi] & ~inhibit_q),
        .send_o(in_send_o[gi]),
        .zero_len_o(in_zero_len_o[gi]),
        .nak_o(in_nak_o[gi])
      );
    end
  endgenerate

  // =====================================================
  // outputs
  assign reg_rdata_o = rdata_q;
  assign usb_inhibit_o = inhibit_q;
  assign suspend_status_o = suspend_q;
  assign resume_drive_o = resume_q;
  assign usb_irq_o = usb_irq_q;
  assign cpu_irq_o = cpu_irq_q;

endmodule : upfic_top

// *** verif/upfic_top_props.sv ***
// Purpose: port assertions for upfic_top
// Assumes: common enables left at reset value
// Notes: bind after endmodule
module upfic_top_props #(
  parameter int NUM_IN_EP = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire upfic_pkg::upfic_byte_t reg_wdata_i,
  input wire upfic_pkg::upfic_byte_t reg_rdata_o,
  // link events and answers
  input wire logic sof_valid_i,
  input wire logic [10:0] sof_frame_i,
  input wire logic in_token_i,
  input wire logic [NUM_IN_EP-1:0] in_token_ep_i,
  input wire logic [NUM_IN_EP-1:0] ep_is_iso_i,
  input wire logic [NUM_IN_EP-1:0] in_send_o,
  input wire logic [NUM_IN_EP-1:0] in_zero_len_o,
  input wire logic [NUM_IN_EP-1:0] in_nak_o,
  // status
  input wire logic system_ext_irq_enable_i,
  input wire logic usb_inhibit_o,
  input wire logic usb_irq_o,
  input wire logic cpu_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import upfic_pkg::*;
  logic [10:0] frame_q;
  logic [10:0] frame_d;
  logic fres;
  // force-reset write wipes the frame copy
  assign fres = reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[3];
  always_comb begin
    frame_d = frame_q;
    if (fres) frame_d = 11'h000;
    else if (sof_valid_i && !usb_inhibit_o) frame_d = sof_frame_i;
  end
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) frame_q <= 11'h000;
    else frame_q <= frame_d;
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_frame_low_read: assert property (
    reg_rd_i && reg_addr_i == 8'h0c |=> reg_rdata_o == $past(frame_q[7:0])) else $error("frame low mismatch");
  chk_frame_high_read: assert property (
    reg_rd_i && reg_addr_i == 8'h0d |=> reg_rdata_o == {5'h00, $past(frame_q[10:8])}) else $error("frame high bad");
  chk_irq_on_flag: assert property (
    sof_valid_i && !usb_inhibit_o && !fres |=> usb_irq_o) else $error("irq missing after sof");
  chk_flag_read_clear: assert property (
    reg_rd_i && reg_addr_i == 8'h06 && !sof_valid_i |=> !usb_irq_o) else $error("flags not cleared");
  chk_cpu_irq_gate: assert property (
    (!system_ext_irq_enable_i) [*2] |-> !cpu_irq_o) else $error("cpu irq while disabled");
  chk_inhibit_sticky: assert property (
    !usb_inhibit_o && !fres |=> !usb_inhibit_o) else $error("inhibit set by software");
  chk_zero_len_iso: assert property (
    |in_zero_len_o |-> (in_zero_len_o & ~$past(ep_is_iso_i)) == '0) else $error("zero length on non-iso");
  chk_token_answer: assert property (
    in_token_i && !usb_inhibit_o |=> (in_send_o | in_zero_len_o | in_nak_o) == $past(in_token_ep_i))
    else $error("token answer wrong");
endmodule : upfic_top_props

bind upfic_top upfic_top_props #(.NUM_IN_EP(NUM_IN_EP)) upfic_top_props_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .sof_valid_i(sof_valid_i),
  .sof_frame_i(sof_frame_i), .in_token_i(in_token_i), .in_token_ep_i(in_token_ep_i), .ep_is_iso_i(ep_is_iso_i),
  .in_send_o(in_send_o), .in_zero_len_o(in_zero_len_o), .in_nak_o(in_nak_o),
  .system_ext_irq_enable_i(system_ext_irq_enable_i), .usb_inhibit_o(usb_inhibit_o), .usb_irq_o(usb_irq_o),
  .cpu_irq_o(cpu_irq_o)
);

// *** verif/upfic_host_model.sv ***
// Purpose: host side of the link: sof, in tokens, line states
// Assumes: driven at the falling edge
// Notes: released lines show the inverse of the last value
module upfic_host_model #(
  parameter int NUM_IN_EP = 3
) (
  // clock
  input wire logic sys_clk_i,
  // link events
  output logic sof_valid_o,
  output logic [10:0] sof_frame_o,
  output logic in_token_o,
  output logic [NUM_IN_EP-1:0] in_token_ep_o,
  // reset, resume, suspend line states
  output logic [2:0] line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sof_valid_o = 1'b0;
    sof_frame_o = 11'h2aa;
    in_token_o = 1'b0;
    in_token_ep_o = '0;
    line_o = 3'h0;
  end
  task automatic send_sof(input logic [10:0] f);
    @(negedge sys_clk_i);
    sof_valid_o = 1'b1;
    sof_frame_o = f;
    @(negedge sys_clk_i);
    sof_valid_o = 1'b0;
    sof_frame_o = ~f;
  endtask : send_sof
  task automatic send_token(input logic [NUM_IN_EP-1:0] ep);
    @(negedge sys_clk_i);
    in_token_o = 1'b1;
    in_token_ep_o = ep;
    @(negedge sys_clk_i);
    in_token_o = 1'b0;
    in_token_ep_o = ~ep;
  endtask : send_token
  task automatic set_lines(input logic [2:0] l);
    @(negedge sys_clk_i);
    line_o = l;
  endtask : set_lines
endmodule : upfic_host_model

// *** verif/usb_power_frame_interrupt_ctl_bench.sv ***
// Purpose: self-checking bench for upfic_top
// Assumes: ep0 and ep2 iso, ep1 bulk until t_iso makes all three iso
// Notes: inputs change at the falling edge
module usb_power_frame_interrupt_ctl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import upfic_pkg::*;
  logic clk, rst_n, wr_s, rd_s, sofv, tok, sen;
  logic [7:0] addr;
  upfic_byte_t wdata, rdata;
  logic [10:0] sfr;
  logic [2:0] tep, ld, snd, zl, nak, lines, iso;
  logic inh, sst, rdrv, uirq, cirq;
  int fails, compares;
  upfic_top upfic_top_i (.sys_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .sof_valid_i(sofv), .sof_frame_i(sfr),
    .in_token_i(tok), .in_token_ep_i(tep), .in_packet_loaded_i(ld), .ep_is_iso_i(iso),
    .bus_suspend_i(lines[0]), .bus_resume_i(lines[1]), .bus_reset_i(lines[2]), .system_ext_irq_enable_i(sen),
    .in_send_o(snd), .in_zero_len_o(zl), .in_nak_o(nak), .usb_inhibit_o(inh), .suspend_status_o(sst),
    .resume_drive_o(rdrv), .usb_irq_o(uirq), .cpu_irq_o(cirq));
  upfic_host_model upfic_host_model_i (.sys_clk_i(clk), .sof_valid_o(sofv), .sof_frame_o(sfr),
    .in_token_o(tok), .in_token_ep_o(tep), .line_o(lines));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====================================
  // bus and check tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    chk("rdata", e, rdata);
  endtask : rd
  task automatic load(input logic [2:0] m);
    @(negedge clk);
    ld = m;
    @(negedge clk);
    ld = 3'b000;
  endtask : load
  // =====================================
  // scenarios
  task automatic t_reset;
    chk("inhibit", 1'b1, inh);
    rd(8'h01, 8'h10);
    upfic_host_model_i.send_sof(11'h123);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h3f, 8'h00);
  endtask : t_reset
  task automatic t_frame;
    wr(8'h01, 8'h00);
    wr(8'h01, 8'h10);
    chk("inhibit", 1'b0, inh);
    upfic_host_model_i.send_sof(11'h5a3);
    rd(8'h0c, 8'ha3);
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h05);
    chk("usb_irq", 1'b1, uirq);
    chk("cpu_irq", 1'b0, cirq);
    sen = 1'b1;
    repeat (2) @(negedge clk);
    chk("cpu_irq", 1'b1, cirq);
    wr(8'h06, 8'h00);
    rd(8'h06, 8'h08);
    chk("usb_irq", 1'b0, uirq);
    rd(8'h06, 8'h00);
    upfic_host_model_i.send_sof(11'h7ff);
    rd(8'h0d, 8'h07);
    rd(8'h0c, 8'hff);
  endtask : t_frame
  task automatic t_iso;
    wr(8'h01, 8'h00);
    load(3'b001);
    upfic_host_model_i.send_token(3'b001);
    chk("send", 3'b001, snd);
    upfic_host_model_i.send_token(3'b010);
    chk("nak", 3'b010, nak);
    wr(8'h01, 8'h80);
    load(3'b101);
    upfic_host_model_i.send_token(3'b001);
    chk("zero_len", 3'b001, zl);
    upfic_host_model_i.send_token(3'b100);
    chk("zero_len", 3'b100, zl);
    upfic_host_model_i.send_sof(11'h001);
    upfic_host_model_i.send_token(3'b001);
    chk("send", 3'b001, snd);
    upfic_host_model_i.send_token(3'b100);
    chk("send", 3'b100, snd);
    iso = 3'b111;
    load(3'b010);
    upfic_host_model_i.send_token(3'b010);
    chk("zero_len", 3'b010, zl);
    upfic_host_model_i.send_sof(11'h002);
    upfic_host_model_i.send_token(3'b010);
    chk("send", 3'b010, snd);
  endtask : t_iso
  task automatic t_suspend;
    rd(8'h06, 8'h08);
    wr(8'h01, 8'h04);
    chk("resume_drive", 1'b0, rdrv);
    upfic_host_model_i.set_lines(3'b001);
    repeat (8) @(negedge clk);
    chk("suspend", 1'b0, sst);
    upfic_host_model_i.set_lines(3'b000);
    wr(8'h01, 8'h01);
    upfic_host_model_i.set_lines(3'b001);
    repeat (8) @(negedge clk);
    chk("suspend", 1'b1, sst);
    rd(8'h01, 8'h03);
    wr(8'h01, 8'h05);
    chk("resume_drive", 1'b1, rdrv);
    wr(8'h01, 8'h01);
    chk("resume_drive", 1'b0, rdrv);
    chk("suspend", 1'b0, sst);
    upfic_host_model_i.set_lines(3'b000);
    repeat (8) @(negedge clk);
    upfic_host_model_i.set_lines(3'b001);
    repeat (8) @(negedge clk);
    upfic_host_model_i.set_lines(3'b010);
    repeat (8) @(negedge clk);
    chk("suspend", 1'b1, sst);
    rd(8'h06, 8'h03);
    chk("suspend", 1'b0, sst);
    upfic_host_model_i.set_lines(3'b000);
  endtask : t_suspend
  task automatic t_force;
    upfic_host_model_i.send_sof(11'h0f0);
    wr(8'h0b, 8'h07);
    rd(8'h0b, 8'h07);
    wr(8'h01, 8'h88);
    @(negedge clk);
    chk("inhibit", 1'b1, inh);
    rd(8'h0c, 8'h00);
    rd(8'h01, 8'h10);
    rd(8'h0b, 8'h0f);
    rd(8'h06, 8'h00);
  endtask : t_force
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end
  initial begin
    fails = 0;
    compares = 0;
    rst_n = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ld = 3'b000;
    sen = 1'b0;
    iso = 3'b101;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_frame();
    t_iso();
    t_suspend();
    t_force();
    report_and_stop();
  end
endmodule : usb_power_frame_interrupt_ctl_bench
